// File: logic/memory_select_map.svh
// Offsets, field positions, reset values and timing counts of the memory select block
// -----------------------------------------------------------------------------
// Notes on behaviour
// - Components sit on three priority levels and where levels overlap the highest level wins.
// - With the example windows, SRAM answers to 87ffh, secondary flash to 9fffh, primary above.
// - Space-map bits 4 and 3 admit read access and bits 2, 1, 0 admit fetch access to memories.
// - The space map loads a boot value and software may rewrite it with immediate effect.
// - Space map 0ch separates fetch to primary flash from reads of secondary and SRAM; bit 7 clear keeps I/O off.
// - Space-map bits 2 and 4 together put primary flash in a combined space.
// - An 8-bit page register sits at offset e0h of the register window, readable and writable.
// - All eight page bits feed the decoder so selects may depend on them.
// - Page bits unused for paging remain visible to the general logic array.
// - The logic arrays take address, four strobes, reset, power-down, ports, page, feedback, ready.
// - With the fast-mode bit clear the arrays go to standby after one 40 ns clock of idle inputs, the 70 ns idle time rounded down to whole cycles.
// - Five bits of power mode register two each block one bus control signal from the arrays.
// - The decoder makes selects for memories, the register window and the I/O ports.
// - A secondary sector overlapping a primary sector takes the access.
// - SRAM and I/O ranges overlapping flash take the access.
// -----------------------------------------------------------------------------
`ifndef MEMORY_SELECT_MAP_SVH
`define MEMORY_SELECT_MAP_SVH

// -----------------------------------------------------------------------------
// Register window offsets
// -----------------------------------------------------------------------------
`define PAGE_EXT_OFFSET 8'he0
`define SPACE_MAP_OFFSET 8'hb0
`define PMR0_OFFSET 8'hb8
`define PMR2_OFFSET 8'hbc

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define SM_PERIPHERAL_IO_ENABLE 7
`define SM_PRI_DATA 4
`define SM_SEC_DATA 3
`define SM_PRI_CODE 2
`define SM_SEC_CODE 1
`define SM_SRAM_CODE 0
`define PMR0_FAST 3
`define PMR2_BLK_FETCH 0
`define PMR2_BLK_RD 1
`define PMR2_BLK_WR 2
`define PMR2_BLK_ALE 3
`define PMR2_BLK_RST 4

// -----------------------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------------------
`define PAGE_RESET 8'h00
`define SPACE_MAP_BOOT 8'h0c
`define PMR0_RESET 8'h08
`define PMR2_RESET 8'h00
`define IDLE_TIME_NS 70
`define CLK_PERIOD_NS 40
`define IDLE_CYCLES (`IDLE_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: logic/memory_select_pkg.sv
// Types shared by the memory select block
`default_nettype none
package memory_select_pkg;

   // Address window of one select equation
   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] hi;
      logic [7:0] page;
      logic [7:0] page_mask;
   } select_window_t;

   // Bus strobes entering the arrays
   typedef struct packed {
      logic fetch;
      logic rd;
      logic wr;
      logic ale;
   } bus_strobe_t;

   // Select outputs of the decoder
   typedef struct packed {
      logic sram;
      logic window;
      logic pio;
      logic sec0;
      logic pri0;
      logic pri1;
   } select_set_t;

   typedef enum logic [1:0] {
      ARRAY_ACTIVE,
      ARRAY_STANDBY
   } array_power_t;

endpackage
`default_nettype wire

// File: logic/window_match.sv
// Range and page match of one select equation
`timescale 1ns/1ps
`default_nettype none
module window_match
   import memory_select_pkg::*;
(
   // Decoder inputs
   input wire logic [15:0] addr,
   input wire logic [7:0] page_bits,
   input wire select_window_t win,
   // Result
   output logic hit
);

   // Window compare with masked page bits
   assign hit = (addr >= win.lo) && (addr <= win.hi)
      && (((page_bits ^ win.page) & win.page_mask) == 8'h00);
endmodule
`default_nettype wire

// File: logic/memory_space_select.sv
// Decode array, space map, page register and power control of the memory select block
`timescale 1ns/1ps
`default_nettype none
`include "memory_select_map.svh"
module memory_space_select
   import memory_select_pkg::*;
#(
   parameter select_window_t PRI0_WIN = '{16'h8000, 16'hbfff, 8'h00, 8'h00},
   parameter select_window_t PRI1_WIN = '{16'hc000, 16'hffff, 8'h00, 8'h00},
   parameter select_window_t SEC0_WIN = '{16'h8000, 16'h9fff, 8'h00, 8'h00},
   parameter select_window_t SRAM_WIN = '{16'h8000, 16'h87ff, 8'h00, 8'h00},
   parameter select_window_t PIO_WIN = '{16'h7000, 16'h70ff, 8'h00, 8'h00},
   parameter logic [15:0] WINDOW_BASE = 16'h7f00,
   parameter logic [7:0] SPACE_MAP_INIT = `SPACE_MAP_BOOT
)(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Core bus
   input wire logic [15:0] addr,
   input wire bus_strobe_t strobe,
   input wire logic bus_reset,
   input wire logic power_down,
   input wire logic [7:0] wdata,
   input wire logic flash_ready,
   // Port and macrocell inputs to the general array
   input wire logic [19:0] port_inputs,
   input wire logic [15:0] mcell_feedback,
   // Data return
   output logic [7:0] rdata,
   output logic rdata_oe,
   // Selects
   output select_set_t selects,
   // General array inputs
   output logic [7:0] general_page_bits,
   output logic [3:0] general_strobes,
   output logic [15:0] general_addr,
   output logic general_misc,
   output logic array_standby
);

   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] space_map;
      logic [7:0] pmr0;
      logic [7:0] pmr2;
      logic [7:0] rdata;
      logic rdata_oe;
      select_set_t sel;
      logic [7:0] gpage;
      logic [3:0] gstrobe;
      logic [15:0] gaddr;
      logic gmisc;
      logic [1:0] idle_cnt;
      array_power_t power;
      logic [36:0] last_in;
   } state_t;

   localparam logic [1:0] IDLE_CNT = 2'(`IDLE_CYCLES);

   state_t st_r;
   state_t st_nxt;
   logic hit_pri0;
   logic hit_pri1;
   logic hit_sec0;
   logic hit_sram;
   logic hit_pio;

   // ---------------------------------------------------------------------------
   // Window matches
   // ---------------------------------------------------------------------------
   window_match u_pri0 (.addr(addr), .page_bits(st_r.page), .win(PRI0_WIN), .hit(hit_pri0));
   window_match u_pri1 (.addr(addr), .page_bits(st_r.page), .win(PRI1_WIN), .hit(hit_pri1));
   window_match u_sec0 (.addr(addr), .page_bits(st_r.page), .win(SEC0_WIN), .hit(hit_sec0));
   window_match u_sram (.addr(addr), .page_bits(st_r.page), .win(SRAM_WIN), .hit(hit_sram));
   window_match u_pio (.addr(addr), .page_bits(st_r.page), .win(PIO_WIN), .hit(hit_pio));

   // Offset test within the register window
   function automatic logic reg_hit(input logic [15:0] a, input logic [7:0] off);
      reg_hit = (a == (WINDOW_BASE | {8'h00, off}));
   endfunction

   // ---------------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------------
   always_comb begin
      logic fetch_g;
      logic rd_g;
      logic wr_g;
      logic ale_g;
      logic rst_g;
      logic win_hit;
      logic level1;
      logic level2;
      logic [36:0] now_in;
      fetch_g = 1'b0;
      rd_g = 1'b0;
      wr_g = 1'b0;
      ale_g = 1'b0;
      rst_g = 1'b0;
      win_hit = 1'b0;
      level1 = 1'b0;
      level2 = 1'b0;
      now_in = '0;
      st_nxt = st_r;
      // Gated strobes into the arrays
      fetch_g = strobe.fetch & ~st_r.pmr2[`PMR2_BLK_FETCH];
      rd_g = strobe.rd & ~st_r.pmr2[`PMR2_BLK_RD];
      wr_g = strobe.wr & ~st_r.pmr2[`PMR2_BLK_WR];
      ale_g = strobe.ale & ~st_r.pmr2[`PMR2_BLK_ALE];
      rst_g = bus_reset & ~st_r.pmr2[`PMR2_BLK_RST];
      win_hit = (addr[15:8] == WINDOW_BASE[15:8]) && (rd_g || wr_g);
      // Level one: SRAM, register window, peripheral I/O
      st_nxt.sel.sram = hit_sram && (rd_g || wr_g || (fetch_g && st_r.space_map[`SM_SRAM_CODE]));
      st_nxt.sel.window = win_hit;
      st_nxt.sel.pio = hit_pio && st_r.space_map[`SM_PERIPHERAL_IO_ENABLE] && (rd_g || wr_g);
      level1 = st_nxt.sel.sram || st_nxt.sel.window || st_nxt.sel.pio;
      // Level two: secondary flash
      st_nxt.sel.sec0 = !level1 && hit_sec0
         && ((rd_g && st_r.space_map[`SM_SEC_DATA])
         || (fetch_g && st_r.space_map[`SM_SEC_CODE]) || wr_g);
      level2 = st_nxt.sel.sec0;
      // Level three: primary flash, combined when both bits are set
      st_nxt.sel.pri0 = !level1 && !level2 && hit_pri0
         && ((rd_g && st_r.space_map[`SM_PRI_DATA])
         || (fetch_g && st_r.space_map[`SM_PRI_CODE]) || wr_g);
      st_nxt.sel.pri1 = !level1 && !level2 && hit_pri1
         && ((rd_g && st_r.space_map[`SM_PRI_DATA])
         || (fetch_g && st_r.space_map[`SM_PRI_CODE]) || wr_g);
      // Register writes take effect on the next access
      if (wr_g && reg_hit(addr, `PAGE_EXT_OFFSET)) begin
         st_nxt.page = wdata;
      end
      if (wr_g && reg_hit(addr, `SPACE_MAP_OFFSET)) begin
         st_nxt.space_map = wdata;
      end
      if (wr_g && reg_hit(addr, `PMR0_OFFSET)) begin
         st_nxt.pmr0 = wdata;
      end
      if (wr_g && reg_hit(addr, `PMR2_OFFSET)) begin
         st_nxt.pmr2 = {3'h0, wdata[4:0]};
      end
      // Register reads; nothing driven otherwise
      st_nxt.rdata = 8'h00;
      st_nxt.rdata_oe = 1'b0;
      if (rd_g && reg_hit(addr, `PAGE_EXT_OFFSET)) begin
         st_nxt.rdata = st_r.page;
         st_nxt.rdata_oe = 1'b1;
      end else if (rd_g && reg_hit(addr, `SPACE_MAP_OFFSET)) begin
         st_nxt.rdata = st_r.space_map;
         st_nxt.rdata_oe = 1'b1;
      end else if (rd_g && reg_hit(addr, `PMR0_OFFSET)) begin
         st_nxt.rdata = st_r.pmr0;
         st_nxt.rdata_oe = 1'b1;
      end else if (rd_g && reg_hit(addr, `PMR2_OFFSET)) begin
         st_nxt.rdata = st_r.pmr2;
         st_nxt.rdata_oe = 1'b1;
      end
      // General array inputs
      st_nxt.gpage = st_r.page;
      st_nxt.gstrobe = {fetch_g, rd_g, wr_g, ale_g};
      st_nxt.gaddr = addr;
      st_nxt.gmisc = rst_g ^ power_down ^ flash_ready ^ (^port_inputs) ^ (^mcell_feedback);
      // Standby after idle inputs with fast mode off
      now_in = {addr, fetch_g, rd_g, wr_g, ale_g, rst_g, power_down, flash_ready, st_r.page,
         st_r.pmr0[`PMR0_FAST], 5'h00};
      st_nxt.last_in = now_in;
      if (now_in != st_r.last_in || st_r.pmr0[`PMR0_FAST]) begin
         st_nxt.idle_cnt = 2'h0;
         st_nxt.power = ARRAY_ACTIVE;
      end else if (st_r.idle_cnt >= IDLE_CNT - 2'h1) begin
         st_nxt.power = ARRAY_STANDBY;
      end else begin
         st_nxt.idle_cnt = st_r.idle_cnt + 2'h1;
      end
   end

   // ---------------------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.page <= `PAGE_RESET;
         st_r.space_map <= SPACE_MAP_INIT;
         st_r.pmr0 <= `PMR0_RESET;
         st_r.pmr2 <= `PMR2_RESET;
         st_r.power <= ARRAY_ACTIVE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state
   assign rdata = st_r.rdata;
   assign rdata_oe = st_r.rdata_oe;
   assign selects = st_r.sel;
   assign general_page_bits = st_r.gpage;
   assign general_strobes = st_r.gstrobe;
   assign general_addr = st_r.gaddr;
   assign general_misc = st_r.gmisc;
   assign array_standby = (st_r.power == ARRAY_STANDBY);

   // ---------------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------------
   property p_level_one;
      @(posedge core_clk) disable iff (!reset_n) selects.sram |-> !selects.sec0 && !selects.pri0;
   endproperty
   a_level_one: assert property (p_level_one) else $error("sram select overlapped flash");

   property p_sec_over_pri;
      @(posedge core_clk) disable iff (!reset_n) selects.sec0 |-> !selects.pri0 && !selects.pri1;
   endproperty
   a_sec_over_pri: assert property (p_sec_over_pri) else $error("primary beat secondary");

   property p_fetch_gate;
      @(posedge core_clk) disable iff (!reset_n)
         (strobe.fetch && !strobe.rd && !strobe.wr && !st_r.space_map[`SM_PRI_CODE])
         |=> !selects.pri0;
   endproperty
   a_fetch_gate: assert property (p_fetch_gate) else $error("fetch reached gated flash");

   property p_read_gate;
      @(posedge core_clk) disable iff (!reset_n)
         (strobe.rd && !strobe.fetch && !strobe.wr && !st_r.space_map[`SM_SEC_DATA])
         |=> !selects.sec0;
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("read reached gated flash");

   property p_map_write;
      @(posedge core_clk) disable iff (!reset_n)
         (strobe.wr && !st_r.pmr2[`PMR2_BLK_WR] && reg_hit(addr, `SPACE_MAP_OFFSET))
         |=> st_r.space_map == $past(wdata);
   endproperty
   a_map_write: assert property (p_map_write) else $error("space map write lost");

   property p_page_read;
      @(posedge core_clk) disable iff (!reset_n)
         (strobe.rd && !st_r.pmr2[`PMR2_BLK_RD] && reg_hit(addr, `PAGE_EXT_OFFSET))
         |=> rdata_oe && rdata == $past(st_r.page);
   endproperty
   a_page_read: assert property (p_page_read) else $error("page read wrong");

   property p_page_general;
      @(posedge core_clk) disable iff (!reset_n) ##1 general_page_bits == $past(st_r.page);
   endproperty
   a_page_general: assert property (p_page_general) else $error("page bits not forwarded");

   property p_fast_active;
      @(posedge core_clk) disable iff (!reset_n) st_r.pmr0[`PMR0_FAST] |=> !array_standby;
   endproperty
   a_fast_active: assert property (p_fast_active) else $error("standby in fast mode");

   property p_no_match;
      @(posedge core_clk) disable iff (!reset_n)
         !(strobe.fetch || strobe.rd || strobe.wr) |=> selects == '0 && !rdata_oe;
   endproperty
   a_no_match: assert property (p_no_match) else $error("select without access");

   property p_block_rd;
      @(posedge core_clk) disable iff (!reset_n)
         st_r.pmr2[`PMR2_BLK_RD] |=> !general_strobes[2];
   endproperty
   a_block_rd: assert property (p_block_rd) else $error("blocked read entered array");
endmodule
`default_nettype wire

// File: tb/core_bus_model.sv
// Core bus master model facing the memory select block
`timescale 1ns/1ps
`default_nettype none
module core_bus_model
   import memory_select_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Requests from the bench
   input wire bus_strobe_t req,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_wdata,
   // Bus toward the block
   output bus_strobe_t strobe,
   output logic [15:0] addr,
   output logic [7:0] wdata
);
   logic [15:0] last_addr_r;
   logic [7:0] last_wdata_r;
   wire logic active = |req;

   // -----------------------------------------------------------------------
   // Bus drive
   // -----------------------------------------------------------------------
   // Released address and data lines show the inverse of the last driven value
   assign strobe = req;
   assign addr = active ? req_addr : ~last_addr_r;
   assign wdata = active ? req_wdata : ~last_wdata_r;

   // Remember the last driven address and data
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_addr_r <= 16'h0000;
         last_wdata_r <= 8'h00;
      end else if (active) begin
         last_addr_r <= req_addr;
         last_wdata_r <= req_wdata;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the memory select block
`timescale 1ns/1ps
`default_nettype none
`include "memory_select_map.svh"
module tb;
   import memory_select_pkg::*;
   typedef struct packed {bus_strobe_t s; logic [15:0] a; logic [5:0] e;} row_t;
   localparam bus_strobe_t F = 4'h8, RD = 4'h4, WR = 4'h2, NO = 4'h0;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   bus_strobe_t req = NO;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0] req_wdata = 8'h00;
   bus_strobe_t strobe;
   logic [15:0] addr, general_addr;
   logic [7:0] wdata, rdata, general_page_bits;
   logic rdata_oe, array_standby, general_misc;
   logic [3:0] general_strobes;
   select_set_t selects;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   // Selects: sram 20, window 10, pio 08, sec0 04, pri0 02, pri1 01
   row_t rows [15] = '{'{F, 16'h8000, 6'h02}, '{F, 16'h9000, 6'h02}, '{F, 16'ha000, 6'h02},
      '{F, 16'hc000, 6'h01}, '{RD, 16'h8000, 6'h20}, '{RD, 16'h87ff, 6'h20},
      '{RD, 16'h8800, 6'h04}, '{RD, 16'h9fff, 6'h04}, '{RD, 16'ha000, 6'h00},
      '{RD, 16'h7000, 6'h00}, '{RD, 16'h0100, 6'h00}, '{WR, 16'h8000, 6'h20},
      '{WR, 16'h8800, 6'h04}, '{WR, 16'ha000, 6'h02}, '{RD, 16'h7fe0, 6'h10}};

   // -----------------------------------------------------------------------
   // Clock, partner and block
   // -----------------------------------------------------------------------
   always #20 core_clk = ~core_clk;

   core_bus_model bus_u (.core_clk(core_clk), .reset_n(reset_n), .req(req),
      .req_addr(req_addr), .req_wdata(req_wdata), .strobe(strobe), .addr(addr),
      .wdata(wdata));

   // Default windows keep same-level ranges apart; I/O window keyed to page 5a
   memory_space_select #(.PIO_WIN('{16'h7000, 16'h70ff, 8'h5a, 8'hff})) dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .addr(addr),
      .strobe(strobe), .bus_reset(1'b0), .power_down(1'b0), .wdata(wdata),
      .flash_ready(1'b1), .port_inputs(20'h00000), .mcell_feedback(16'h0000),
      .rdata(rdata), .rdata_oe(rdata_oe), .selects(selects),
      .general_page_bits(general_page_bits), .general_strobes(general_strobes),
      .general_addr(general_addr), .general_misc(general_misc),
      .array_standby(array_standby));

   // -----------------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------------
   task automatic final_report();
      if (num_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One bus cycle from a falling edge to the next, answer checked after it
   task automatic op(input bus_strobe_t s, input logic [15:0] a, input logic [7:0] d);
      req = s;
      req_addr = a;
      req_wdata = d;
      @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic reg_rd(input logic [7:0] off, input logic [7:0] exp);
      op(RD, {8'h7f, off}, 8'h00);
      chk("rdata_oe", {15'h0000, rdata_oe}, 16'h0001);
      chk("rdata", {8'h00, rdata}, {8'h00, exp});
   endtask

   // Cycle ceiling
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end

   // -----------------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      chk("selects in reset", {10'h000, selects}, 16'h0000);
      reset_n = 1'b1;
      op(NO, 16'h0000, 8'h00);
      chk("standby fast", {15'h0000, array_standby}, 16'h0000);
      reg_rd(`SPACE_MAP_OFFSET, `SPACE_MAP_BOOT);
      reg_rd(`PAGE_EXT_OFFSET, 8'h00);
      // Boot map: table of fetch, read and write decodes
      foreach (rows[i]) begin
         op(rows[i].s, rows[i].a, 8'h00);
         chk("selects", {10'h000, selects}, {10'h000, rows[i].e});
         chk("general addr", general_addr, rows[i].a);
         chk("rdata_oe", {15'h0000, rdata_oe}, {15'h0000, rows[i].e == 6'h10});
      end
      chk("general misc", {15'h0000, general_misc}, 16'h0001);
      // Page register write, read back and feed to the general array
      op(WR, {8'h7f, `PAGE_EXT_OFFSET}, 8'h5a);
      reg_rd(`PAGE_EXT_OFFSET, 8'h5a);
      chk("general page", {8'h00, general_page_bits}, 16'h005a);
      // Combined space for primary flash
      op(WR, {8'h7f, `SPACE_MAP_OFFSET}, 8'h14);
      op(RD, 16'ha000, 8'h00);
      chk("selects rd", {10'h000, selects}, 16'h0002);
      op(F, 16'ha000, 8'h00);
      chk("selects fetch", {10'h000, selects}, 16'h0002);
      op(RD, 16'h8800, 8'h00);
      chk("selects sec gated", {10'h000, selects}, 16'h0002);
      reg_rd(`SPACE_MAP_OFFSET, 8'h14);
      // Rewrite applies to the very next access
      op(WR, {8'h7f, `SPACE_MAP_OFFSET}, 8'h01);
      op(F, 16'h8000, 8'h00);
      chk("selects sram fetch", {10'h000, selects}, 16'h0020);
      op(WR, {8'h7f, `SPACE_MAP_OFFSET}, 8'h80);
      op(RD, 16'h7000, 8'h00);
      chk("selects pio", {10'h000, selects}, 16'h0008);
      // Another page no longer matches the page-keyed I/O window
      op(WR, {8'h7f, `PAGE_EXT_OFFSET}, 8'h00);
      op(RD, 16'h7000, 8'h00);
      chk("selects page miss", {10'h000, selects}, 16'h0000);
      op(WR, {8'h7f, `PAGE_EXT_OFFSET}, 8'h5a);
      // Standby with fast mode off and idle inputs
      op(WR, {8'h7f, `PMR0_OFFSET}, 8'h00);
      repeat (4) op(NO, 16'h0000, 8'h00);
      chk("standby", {15'h0000, array_standby}, 16'h0001);
      op(WR, {8'h7f, `PMR0_OFFSET}, 8'h08);
      // Blocked write strobe leaves the page untouched
      op(WR, {8'h7f, `PMR2_OFFSET}, 8'h04);
      op(WR, {8'h7f, `PAGE_EXT_OFFSET}, 8'h33);
      chk("strobes wr blocked", {12'h000, general_strobes}, 16'h0000);
      reg_rd(`PAGE_EXT_OFFSET, 8'h5a);
      chk("strobes rd", {12'h000, general_strobes}, 16'h0004);
      // Second reset restores the boot values
      reset_n = 1'b0;
      op(NO, 16'h0000, 8'h00);
      reset_n = 1'b1;
      reg_rd(`PAGE_EXT_OFFSET, 8'h00);
      reg_rd(`SPACE_MAP_OFFSET, `SPACE_MAP_BOOT);
      reg_rd(`PMR2_OFFSET, 8'h00);
      // Blocked read strobe reaches neither array nor register read
      op(WR, {8'h7f, `PMR2_OFFSET}, 8'h02);
      op(RD, {8'h7f, `PAGE_EXT_OFFSET}, 8'h00);
      chk("strobes rd blocked", {12'h000, general_strobes}, 16'h0000);
      chk("rdata_oe rd blocked", {15'h0000, rdata_oe}, 16'h0000);
      final_report();
   end
endmodule
`default_nettype wire
